// *** hw/sbs_pkg.sv ***
/*
 Constants, write-request carrier and burst address function for the synchronous burst SRAM port.
 Assumes one 125 MHz clock and the wide (36-bit) data variant.
*/
// Function
// - Common data bus of 36 or 18 bits, one set of pins for read and write.
// - Every synchronous input is sampled on the rising clock edge.
// - A 2-bit counter clears to zero at the burst start and then increments.
// - Burst order is interleaved when the order input is high, linear when low.
// - Either address strobe may start a burst.
// - Address and chip selects are captured only when a strobe is asserted.
// - After the first beat the burst address steps only on the advance input.
// - Output enable and sleep act asynchronously, without waiting for an edge.
// - Bursts run at two cycles for the first beat, one for each other beat.
package sbs_pkg;
	localparam int DATA_W = 36;
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int MEM_DEPTH = 524288;
	localparam int FIFO_DEPTH = 8;
	localparam int BURST_W = 2;
	localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANES-1:0] lane_we;
	} sbs_wr_type;

	// Low address bits of the current beat
	function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] cnt, input logic interleave);
		return interleave ? (start ^ cnt) : BURST_W'(start + cnt);
	endfunction : burst_low
endpackage : sbs_pkg

// *** hw/sbs_fifo.sv ***
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module sbs_fifo #(
	parameter int WIDTH = 59,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] store_q [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	logic push;
	logic pop;

	assign in_ready_o = (count_q != (PW+1)'(DEPTH));
	assign out_valid_o = (count_q != '0);
	assign out_data_o = store_q[rd_ptr_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			store_q[wr_ptr_q] <= in_data_i;
		end
	end

	// Pointers wrap by width, so depth must be a power of two
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
			end
			if (pop) begin
				rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
			end
			if (push && !pop) begin
				count_q <= (PW+1)'(count_q + 1'b1);
			end else if (pop && !push) begin
				count_q <= (PW+1)'(count_q - 1'b1);
			end
		end
	end
endmodule : sbs_fifo

// *** hw/sbs_sram_port.sv ***
/*
 Synchronous flow-through burst SRAM core: address capture, burst counter, write buffer, storage.
 Assumes the controller keeps inputs stable around the rising edge and obeys no wait signal;
 the testbench resolves the data wire from dq_oe_n_o.
*/
`timescale 1ns/100ps
module sbs_sram_port (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [sbs_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sbs_pkg::DATA_W-1:0] dq_i,
	output logic [sbs_pkg::DATA_W-1:0] dq_o,
	output logic dq_oe_n_o,
	input wire logic chip_select_pipelined_n_i,
	input wire logic depth_select_high_i,
	input wire logic depth_select_low_n_i,
	input wire logic processor_addr_strobe_n_i,
	input wire logic controller_addr_strobe_n_i,
	input wire logic burst_advance_n_i,
	input wire logic [sbs_pkg::LANES-1:0] byte_write_n_i,
	input wire logic byte_write_qualifier_n_i,
	input wire logic all_bytes_write_n_i,
	input wire logic output_enable_n_i,
	input wire logic sleep_request_i,
	input wire logic burst_order_i,
	output logic write_buffer_full_o
);
	typedef enum logic [1:0] {
		SBS_IDLE = 2'b01,
		SBS_BURST = 2'b10
	} sbs_state_type;

	// Storage is flops; each word is 36 bits on the common bus
	logic [sbs_pkg::DATA_W-1:0] mem_q [0:sbs_pkg::MEM_DEPTH-1];
	logic [sbs_pkg::ADDR_W-1:0] base_q;
	logic [sbs_pkg::BURST_W-1:0] cnt_q;
	logic sel_q;
	logic mode_q;
	logic read_q;
	sbs_state_type state_q;

	logic awake;
	logic strobe;
	logic proc_start;
	logic ctrl_start;
	logic cs_in;
	logic [sbs_pkg::LANES-1:0] lane_we_in;
	logic wr_now;
	logic [sbs_pkg::ADDR_W-1:0] cur_addr;
	sbs_pkg::sbs_wr_type push_req;
	sbs_pkg::sbs_wr_type pop_req;
	logic push_ready;
	logic pop_valid;

	assign awake = !sleep_request_i;
	assign proc_start = !processor_addr_strobe_n_i;
	assign ctrl_start = !controller_addr_strobe_n_i & processor_addr_strobe_n_i;
	assign strobe = proc_start | !controller_addr_strobe_n_i;
	assign cs_in = !chip_select_pipelined_n_i & depth_select_high_i & !depth_select_low_n_i;
	assign lane_we_in = !all_bytes_write_n_i ? '1 : (byte_write_qualifier_n_i ? '0 : ~byte_write_n_i);

	// Upper bits as captured, only the low two follow the counter
	assign cur_addr = {base_q[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_W],
		sbs_pkg::burst_low(base_q[sbs_pkg::BURST_W-1:0], cnt_q, mode_q)};

	// A processor-strobe edge never writes; the write data follows on later edges
	always_comb begin
		if (proc_start) begin
			wr_now = 1'b0;
		end else if (ctrl_start) begin
			wr_now = cs_in & (|lane_we_in);
		end else begin
			wr_now = sel_q & (|lane_we_in);
		end
	end

	always_comb begin
		push_req.addr = ctrl_start ? addr_i : cur_addr;
		push_req.data = dq_i;
		push_req.lane_we = lane_we_in;
	end

	// Address, selects and order captured only on a strobe
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			base_q <= sbs_pkg::ADDR_RST;
			sel_q <= 1'b0;
			mode_q <= 1'b0;
		end else if (awake && strobe) begin
			base_q <= addr_i;
			sel_q <= cs_in;
			mode_q <= burst_order_i;
		end
	end

	// Counter loads on a strobe, then steps on advance only
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= sbs_pkg::CNT_RST;
		end else if (awake && strobe) begin
			cnt_q <= sbs_pkg::CNT_RST;
		end else if (awake && sel_q && !burst_advance_n_i) begin
			cnt_q <= sbs_pkg::BURST_W'(cnt_q + 1'b1);
		end
	end

	// Burst tracking: enters burst on a selected strobe, back to idle on an unselected strobe
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= SBS_IDLE;
		end else if (awake) begin
			case (state_q)
				SBS_IDLE: begin
					if (strobe && cs_in) begin
						state_q <= SBS_BURST;
					end
				end
				SBS_BURST: begin
					if (strobe && !cs_in) begin
						state_q <= SBS_IDLE;
					end
				end
				default: begin
					state_q <= SBS_IDLE;
				end
			endcase
		end
	end

	// Read cycle marker: selected and not writing at this edge
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			read_q <= 1'b0;
		end else if (awake) begin
			read_q <= (strobe ? cs_in : sel_q) & !wr_now;
		end else begin
			read_q <= 1'b0;
		end
	end

	// Writes drain one per cycle, so a read one edge later already sees them;
	// push and drain share the sleep gate, so at most one write waits and full stays a guard only
	sbs_fifo #(
		.WIDTH($bits(sbs_pkg::sbs_wr_type)),
		.DEPTH(sbs_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(awake & wr_now),
		.in_ready_o(push_ready),
		.in_data_i(push_req),
		.out_valid_o(pop_valid),
		.out_ready_i(awake),
		.out_data_o(pop_req)
	);

	always_ff @(posedge sys_clk_i) begin
		if (pop_valid && awake) begin
			for (int i = 0; i < sbs_pkg::LANES; i++) begin
				if (pop_req.lane_we[i]) begin
					mem_q[pop_req.addr][i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] <=
						pop_req.data[i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			write_buffer_full_o <= 1'b0;
		end else begin
			write_buffer_full_o <= !push_ready;
		end
	end

	// Flow-through: no output register, data follows the registered address
	assign dq_o = mem_q[cur_addr];
	// Output enable and sleep bypass the clock entirely
	assign dq_oe_n_o = !read_q | output_enable_n_i | sleep_request_i;

	capture_on_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(awake && strobe) |=> (base_q == $past(addr_i) && sel_q == $past(cs_in)))
		else $error("address not captured on strobe");
	hold_no_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(!strobe) |=> $stable(base_q) && $stable(sel_q))
		else $error("address changed without strobe");
	strobe_load_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(awake && (!processor_addr_strobe_n_i || !controller_addr_strobe_n_i)) |=> cnt_q == 2'h0)
		else $error("counter not loaded by strobe");
	counter_step_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(awake && !strobe && sel_q && !burst_advance_n_i) |=> cnt_q == 2'($past(cnt_q) + 2'h1))
		else $error("counter did not step");
	advance_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(!strobe && burst_advance_n_i) |=> $stable(cnt_q))
		else $error("counter moved without advance");
	wrap_upper_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(!strobe && sel_q && !burst_advance_n_i) [*4] |=> cnt_q == $past(cnt_q, 4) && $stable(base_q))
		else $error("burst left its aligned four");
	interleave_order_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		mode_q |-> cur_addr[1:0] == (base_q[1:0] ^ cnt_q))
		else $error("interleaved order wrong");
	linear_order_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!mode_q |-> cur_addr[1:0] == 2'(base_q[1:0] + cnt_q))
		else $error("linear order wrong");
	async_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(output_enable_n_i || sleep_request_i) |-> dq_oe_n_o)
		else $error("bus driven with output disabled");
	first_beat_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(awake && proc_start && cs_in) ##1 (!output_enable_n_i && awake) |-> !dq_oe_n_o && dq_o == mem_q[cur_addr])
		else $error("first read beat missing");
	burst_state_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(awake && strobe) |=> ((state_q == SBS_BURST) == $past(cs_in)))
		else $error("burst state not following the select");
	write_buffer_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(awake && wr_now && push_ready) |=> pop_valid)
		else $error("sampled write not buffered");

	read_burst_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(proc_start && cs_in) ##1 (!burst_advance_n_i && !strobe) [*3]);
	write_burst_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(ctrl_start && wr_now) ##1 (wr_now && !burst_advance_n_i) [*3]);
	sleep_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
		read_q ##1 sleep_request_i);
	interleave_c: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
		mode_q && cnt_q == 2'h3);
endmodule : sbs_sram_port

// *** test/sbs_ctl_model.sv ***
/*
 Controller model that drives the burst SRAM port bus one edge at a time and resolves the data wire.
 Assumes cycle() is entered in the time step of a rising edge.
*/
`timescale 1ns/100ps
module sbs_ctl_model (
	input wire logic sys_clk_i,
	input wire logic [sbs_pkg::DATA_W-1:0] rd_i,
	input wire logic oe_n_i,
	output logic [sbs_pkg::ADDR_W-1:0] addr_o,
	output logic [sbs_pkg::DATA_W-1:0] wire_o,
	output logic sel_n_o,
	output logic pstb_n_o,
	output logic cstb_n_o,
	output logic step_n_o,
	output logic wr_all_n_o,
	output logic [sbs_pkg::DATA_W-1:0] rd_o
);
	logic [sbs_pkg::DATA_W-1:0] wd_q = '0;
	logic [sbs_pkg::DATA_W-1:0] last_q = '0;
	// Undriven wire flips each cycle so a stale word never passes for a read
	assign wire_o = !oe_n_i ? rd_i : (!wr_all_n_o ? wd_q : ~last_q);
	always @(posedge sys_clk_i) last_q <= wire_o;
	initial begin
		addr_o = '0;
		sel_n_o = 1'b1;
		pstb_n_o = 1'b1;
		cstb_n_o = 1'b1;
		step_n_o = 1'b1;
		wr_all_n_o = 1'b1;
		rd_o = '0;
	end
	// Inputs change just after an edge and hold through the next one
	task automatic cycle(input logic ps_n, input logic cs_n, input logic sel_n, input logic st_n,
		input logic wr, input logic [sbs_pkg::ADDR_W-1:0] a, input logic [sbs_pkg::DATA_W-1:0] d);
		pstb_n_o <= ps_n;
		cstb_n_o <= cs_n;
		sel_n_o <= sel_n;
		step_n_o <= st_n;
		wr_all_n_o <= !wr;
		addr_o <= a;
		wd_q <= d;
		@(negedge sys_clk_i);
		rd_o = wire_o;
		@(posedge sys_clk_i);
	endtask : cycle
endmodule : sbs_ctl_model

// *** test/sbs_sram_port_bench.sv ***
/*
 Self-checking bench for the burst SRAM port, its write buffer reached through the port's own pins.
 Assumes the controller model owns the data wire.
*/
`timescale 1ns/100ps
module sbs_sram_port_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic oe_n = 1'b1;
	logic sleep = 1'b0;
	logic order = 1'b0;
	logic [sbs_pkg::DATA_W-1:0] rdq, wire_v, rd_v;
	logic [sbs_pkg::ADDR_W-1:0] addr;
	logic dq_oe_n, sel_n, ps_n, cs_n, st_n, wa_n, full;
	int errors = 0;
	int total_checks = 0;
	always #4 clk = ~clk;
	sbs_ctl_model ctl (.sys_clk_i(clk), .rd_i(rdq), .oe_n_i(dq_oe_n), .addr_o(addr), .wire_o(wire_v),
		.sel_n_o(sel_n), .pstb_n_o(ps_n), .cstb_n_o(cs_n), .step_n_o(st_n), .wr_all_n_o(wa_n), .rd_o(rd_v));
	sbs_sram_port dut (.sys_clk_i(clk), .rstn_i(rstn), .addr_i(addr), .dq_i(wire_v), .dq_o(rdq),
		.dq_oe_n_o(dq_oe_n), .chip_select_pipelined_n_i(sel_n), .depth_select_high_i(1'b1),
		.depth_select_low_n_i(1'b0), .processor_addr_strobe_n_i(ps_n), .controller_addr_strobe_n_i(cs_n),
		.burst_advance_n_i(st_n), .byte_write_n_i(4'hF), .byte_write_qualifier_n_i(1'b1),
		.all_bytes_write_n_i(wa_n), .output_enable_n_i(oe_n), .sleep_request_i(sleep),
		.burst_order_i(order), .write_buffer_full_o(full));
	function automatic logic [35:0] wd(input logic [18:0] a);
		return {a, 17'h15A5A};
	endfunction : wd
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	// Controller strobe opens, four stepped writes follow
	task automatic t_write(input logic [18:0] a);
		oe_n <= 1'b1;
		order <= 1'b0;
		ctl.cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, a, 36'h0);
		for (int i = 0; i < 4; i++) ctl.cycle(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, a, wd(a + 19'(i)));
		$display("write burst done");
	endtask : t_write
	task automatic t_read(input logic ps, input logic il, input logic [18:0] a);
		logic [1:0] lo;
		order <= il;
		oe_n <= 1'b0;
		ctl.cycle(!ps, ps, 1'b0, 1'b1, 1'b0, a, 36'h0);
		for (int i = 0; i < 4; i++) begin
			ctl.cycle(1'b1, 1'b1, 1'b0, i == 3, 1'b0, a, 36'h0);
			lo = il ? (a[1:0] ^ 2'(i)) : 2'(a[1:0] + 2'(i));
			check(rd_v, wd({a[18:2], lo}));
		end
		$display("read burst done");
	endtask : t_read
	task automatic t_hold(input logic [18:0] a);
		ctl.cycle(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, a, 36'h0);
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, a + 19'h1, 36'h0);
		check(rd_v, wd(a));
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, a, 36'h0);
		check(rd_v, wd(a));
		#2 oe_n = 1'b1;
		#1 check(dq_oe_n, 1'b1);
		oe_n = 1'b0;
		#1 check(dq_oe_n, 1'b0);
		sleep = 1'b1;
		#1 check(dq_oe_n, 1'b1);
		sleep = 1'b0;
		@(posedge clk);
		ctl.cycle(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, a, 36'h0);
		#1 check(dq_oe_n, 1'b1);
		@(posedge clk);
		$display("hold and async done");
	endtask : t_hold
	// Write at a strobe edge, read it back one edge later through the buffer, then a write refused in sleep
	task automatic t_buffer(input logic [18:0] a);
		oe_n <= 1'b1;
		ctl.cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, a, ~wd(a));
		oe_n <= 1'b0;
		ctl.cycle(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, a, 36'h0);
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, a, 36'h0);
		check(rd_v, ~wd(a));
		check(full, 1'b0);
		sleep <= 1'b1;
		ctl.cycle(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, a, wd(a));
		check(dq_oe_n, 1'b1);
		sleep <= 1'b0;
		ctl.cycle(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, a, 36'h0);
		ctl.cycle(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, a, 36'h0);
		check(rd_v, ~wd(a));
		check(full, 1'b0);
		$display("buffer done");
	endtask : t_buffer
	initial begin
		#20000;
		errors++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		check({dq_oe_n, full}, 2'h2);
		t_write(19'h00100);
		t_write(19'h7FFFC);
		t_read(1'b1, 1'b0, 19'h00102);
		t_read(1'b0, 1'b1, 19'h00101);
		t_read(1'b1, 1'b1, 19'h7FFFE);
		t_read(1'b0, 1'b0, 19'h7FFFF);
		t_hold(19'h00103);
		t_buffer(19'h00101);
		end_of_test();
	end
endmodule : sbs_sram_port_bench
